// ---- core/ubsd_decoder.v ----
// Utility bus chip select decode, media change, fpu error handshake
// Notes on behaviour
// R1 - Bank select low picks first decoder, high picks second, with code.
// R2 - Bank low: 000 clock addr write, 001 clock data, 010 keyboard.
// R3 - Boot ROM code 011 always for top 64 KB below 1 MB and aliases.
// R4 - Lower 64 KB segment and extra top region only when enabled.
// R5 - Bank low: 100 diskette, 101 disk command, 110 disk control.
// R6 - One setting picks primary or secondary for diskette and disk.
// R7 - Bank high: 001 config page 0C00h, 010 config RAM 0800h-08FFh.
// R8 - Bank high: 011 serial A, 100 serial B, each range programmable.
// R9 - Bank high: 101 printer, one of three ranges, none for range code 3.
// R10 - Idle is bank high with code 111; reserved codes never driven.
// R11 - Port 92h register drives alternate reset and alternate A20 gate.
// R12 - Diskette status reads drive data bit 7 with inverted media change.
// R13 - Bit 7 driven only with diskette on, disk off; buffer off then.
// R14 - Fpu error reporting only when divisor bit 5 is set.
// R15 - Fpu error in reporting mode raises request 13 and interrupt.
// R16 - Write to F0h withdraws request 13 and asserts ignore-error.
// R17 - Ignore-error holds until error goes away or mode goes off, never without error.
// R18 - Two outputs control the low data byte buffer: enable, direction.
`timescale 1ns/100ps
`include "ubsd_defs.vh"

module ubsd_decoder (
    // Clock, reset, enable
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire clk_en_i,
    // Host cycle, already in this clock domain
    input wire [31:0] addr_i,
    input wire io_rd_i,
    input wire io_wr_i,
    input wire mem_rd_i,
    input wire mem_wr_i,
    input wire [7:0] wr_data_i,
    // Configuration bits
    input wire rom_low_seg_en_i,
    input wire rom_ext_en_i,
    input wire dskt_dec_en_i,
    input wire disk_dec_en_i,
    input wire disk_secondary_i,
    input wire serial_a_second_i,
    input wire serial_b_second_i,
    input wire serial_a_en_i,
    input wire serial_b_en_i,
    input wire [1:0] printer_range_i,
    input wire printer_en_i,
    input wire [7:0] clk_divisor_i,
    // Pins from outside
    input wire media_change_in_i,
    input wire fpu_error_in_n_i,
    // Select outputs
    output reg [2:0] encoded_select_code_o,
    output reg decoder_bank_select_n_o,
    // Data bit 7 and buffer control
    output reg sd7_o,
    output reg sd7_oe_o,
    output reg util_buffer_out_en_n_o,
    output reg util_buffer_direction_o,
    // Port 92h and fpu handshake
    output reg alternate_reset_o,
    output reg alternate_gate_a20_o,
    output reg irq13_o,
    output reg int_o,
    output reg fpu_ignore_error_n_o
);

// Match an I/O address against an aligned window of 2^bits bytes
function in_win;
    input [15:0] a;
    input [15:0] base;
    input [3:0] bits;
    reg [15:0] mask;
    begin
        mask = 16'hffff << bits;
        in_win = ((a & mask) == (base & mask));
    end
endfunction

reg media_s1, media_s2, fpu_error_in_n_s1, fpu_error_in_n_s2;
reg [1:0] sysctl;
reg ignore_err;
reg irq13;
reg [2:0] next_code;
reg next_bank_n;
reg next_sd7_oe;
reg next_oe_n;
reg io_any;
reg fpu_mode;
wire [15:0] ioa;
wire [15:0] mhi;
wire io_cyc;
wire mem_cyc;
wire fpu_error_in_n_act;
wire [15:0] dskt_b, dcmd_b, dctl_b, dstat_a;

assign ioa = addr_i[15:0];
assign mhi = addr_i[31:16];
assign io_cyc = io_rd_i | io_wr_i;
assign mem_cyc = mem_rd_i | mem_wr_i;
assign fpu_error_in_n_act = ~fpu_error_in_n_s2;
// Single setting steers both diskette and disk windows
assign dskt_b = disk_secondary_i ? `UBSD_IO_DSKT_SEC
                                 : `UBSD_IO_DSKT_PRI; // R6
assign dcmd_b = disk_secondary_i ? `UBSD_IO_DCMD_SEC
                                 : `UBSD_IO_DCMD_PRI; // R6
assign dctl_b = disk_secondary_i ? `UBSD_IO_DCTL_SEC
                                 : `UBSD_IO_DCTL_PRI; // R6
assign dstat_a = disk_secondary_i ? `UBSD_IO_DSTAT_SEC
                                  : `UBSD_IO_DSTAT_PRI;

// Pins pass two flops before any logic sees them
// Costs two clocks of latency on media change and cpu error
always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
        media_s1 <= 1'b0;
        media_s2 <= 1'b0;
        fpu_error_in_n_s1 <= 1'b1;
        fpu_error_in_n_s2 <= 1'b1;
    end else if (clk_en_i) begin
        media_s1 <= media_change_in_i;
        media_s2 <= media_s1;
        fpu_error_in_n_s1 <= fpu_error_in_n_i;
        fpu_error_in_n_s2 <= fpu_error_in_n_s1;
    end
end

// Serial ranges; second range is not aligned so compare bounds
function ser_hit;
    input [15:0] a;
    input second;
    begin
        if (second)
            ser_hit = (a >= `UBSD_IO_SER2_LO) && (a <= `UBSD_IO_SER2_HI);
        else
            ser_hit = in_win(a, `UBSD_IO_SER1_BASE, 4'h3);
    end
endfunction

// Select decode; earlier entries win, so disk control beats diskette
// Serial second range also covers 378h-37Fh, so serial wins over the
// printer there; software keeps the two apart
always @* begin
    next_code = `UBSD_CODE_IDLE; // R10
    next_bank_n = 1'b1; // R10
    io_any = 1'b0;
    if (mem_cyc) begin
        if (mhi == `UBSD_MEM_SEG_F || mhi == `UBSD_MEM_TOP_F ||
            mhi == `UBSD_MEM_LOW_F) begin
            next_code = `UBSD_CODE_ROM; // R3
            next_bank_n = 1'b0; // R1
        end else if (rom_low_seg_en_i && (mhi == `UBSD_MEM_SEG_E ||
                     mhi == `UBSD_MEM_TOP_E ||
                     mhi == `UBSD_MEM_LOW_E)) begin
            next_code = `UBSD_CODE_ROM; // R4
            next_bank_n = 1'b0;
        end else if (rom_ext_en_i && mhi >= `UBSD_MEM_EXT_LO &&
                     mhi <= `UBSD_MEM_EXT_HI) begin
            next_code = `UBSD_CODE_ROM; // R4
            next_bank_n = 1'b0;
        end
    end else if (io_cyc && addr_i[31:16] == 16'h0000) begin
        io_any = 1'b1;
        if (in_win(ioa, `UBSD_IO_CLK_BASE, 4'h3) && !ioa[0]) begin
            // Address latch select is write only
            if (io_wr_i) begin
                next_code = `UBSD_CODE_CLK_ADDR; // R2
                next_bank_n = 1'b0;
            end
        end else if (in_win(ioa, `UBSD_IO_CLK_BASE, 4'h3)) begin
            next_code = `UBSD_CODE_CLK_DATA; // R2
            next_bank_n = 1'b0;
        end else if (in_win(ioa, `UBSD_IO_KBD_BASE, 4'h3) && !ioa[0]) begin
            next_code = `UBSD_CODE_KBD; // R2
            next_bank_n = 1'b0;
        end else if (disk_dec_en_i && in_win(ioa, dctl_b, 4'h1)) begin
            next_code = `UBSD_CODE_DCTL; // R5
            next_bank_n = 1'b0;
        end else if (dskt_dec_en_i && in_win(ioa, dskt_b, 4'h3)) begin
            next_code = `UBSD_CODE_DSKT; // R5
            next_bank_n = 1'b0;
        end else if (disk_dec_en_i && in_win(ioa, dcmd_b, 4'h3)) begin
            next_code = `UBSD_CODE_DCMD; // R5
            next_bank_n = 1'b0;
        end else if (ioa == `UBSD_IO_CPAGE) begin
            next_code = `UBSD_CODE_CPAGE; // R7
        end else if (in_win(ioa, `UBSD_IO_CRAM_BASE, 4'h8)) begin
            next_code = `UBSD_CODE_CRAM; // R7
        end else if (serial_a_en_i && ser_hit(ioa, serial_a_second_i)) begin
            next_code = `UBSD_CODE_SERA; // R8
        end else if (serial_b_en_i && ser_hit(ioa, serial_b_second_i)) begin
            next_code = `UBSD_CODE_SERB; // R8
        end else if (printer_en_i) begin
            case (printer_range_i)
            `UBSD_PRN_SEL1: begin
                if (in_win(ioa, `UBSD_IO_PRN1_BASE, 4'h2))
                    next_code = `UBSD_CODE_PRN; // R9
            end
            `UBSD_PRN_SEL2: begin
                if (in_win(ioa, `UBSD_IO_PRN2_BASE, 4'h3))
                    next_code = `UBSD_CODE_PRN; // R9
            end
            `UBSD_PRN_SEL3: begin
                if (in_win(ioa, `UBSD_IO_PRN3_BASE, 4'h3))
                    next_code = `UBSD_CODE_PRN; // R9
            end
            default: begin
                next_code = `UBSD_CODE_IDLE;
            end
            endcase
        end
    end
end

// Media change bit and buffer enable for the status read
// Both decodes on: disk control answers the status read through the buffer
always @* begin
    next_sd7_oe = 1'b0;
    next_oe_n = 1'b1;
    if (io_rd_i && !mem_cyc && addr_i[31:16] == 16'h0000 &&
        ioa == dstat_a && dskt_dec_en_i) begin
        if (!disk_dec_en_i)
            next_sd7_oe = 1'b1; // R13
        else
            next_oe_n = 1'b0; // R13
    end else if (!mem_cyc && io_any && next_code != `UBSD_CODE_IDLE) begin
        next_oe_n = 1'b0; // R18
    end else if (mem_cyc && next_code == `UBSD_CODE_ROM) begin
        next_oe_n = 1'b0; // R18
    end
end

// Outputs are all registered, so they lag the cycle by one clock
always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
        encoded_select_code_o <= `UBSD_CODE_IDLE;
        decoder_bank_select_n_o <= 1'b1;
        sd7_o <= 1'b0;
        sd7_oe_o <= 1'b0;
        util_buffer_out_en_n_o <= 1'b1;
        util_buffer_direction_o <= 1'b0;
    end else if (clk_en_i) begin
        encoded_select_code_o <= next_code; // R1
        decoder_bank_select_n_o <= next_bank_n; // R1
        // Bit 7 value runs free; only its enable follows the read
        sd7_o <= ~media_s2; // R12
        sd7_oe_o <= next_sd7_oe; // R12
        util_buffer_out_en_n_o <= next_oe_n; // R18
        // High carries data from utility bus to system bus on reads
        util_buffer_direction_o <= io_rd_i | mem_rd_i; // R18
    end
end

// Port 92h register
always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
        sysctl <= `UBSD_SYSCTL_RESET;
        alternate_reset_o <= 1'b0;
        alternate_gate_a20_o <= 1'b0;
    end else if (clk_en_i) begin
        if (io_wr_i && !mem_cyc && addr_i == {16'h0000, `UBSD_IO_SYSCTL})
            sysctl <= {wr_data_i[`UBSD_SYSCTL_A20_BIT],
                       wr_data_i[`UBSD_SYSCTL_RST_BIT]}; // R11
        alternate_reset_o <= sysctl[0]; // R11
        alternate_gate_a20_o <= sysctl[1]; // R11
    end
end

// Fpu error handshake; error gone or mode off beats an F0h write
// An F0h write with the error active drops the request and hands
// over to ignore-error, which then holds off a new request
always @* begin
    fpu_mode = clk_divisor_i[`UBSD_FPU_MODE_BIT]; // R14
end

always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
        irq13 <= 1'b0;
        ignore_err <= 1'b0;
        irq13_o <= 1'b0;
        int_o <= 1'b0;
        fpu_ignore_error_n_o <= 1'b1;
    end else if (clk_en_i) begin
        if (!fpu_mode || !fpu_error_in_n_act) begin
            irq13 <= 1'b0;
            ignore_err <= 1'b0; // R17
        end else if (io_wr_i && !mem_cyc &&
                     addr_i == {16'h0000, `UBSD_IO_FPU_CLR}) begin
            irq13 <= 1'b0; // R16
            ignore_err <= 1'b1; // R16
        end else if (!ignore_err) begin
            irq13 <= 1'b1; // R15
        end
        irq13_o <= irq13; // R15
        int_o <= irq13; // R15
        // Gated by the synced error, so it never rises without it;
        // release trails the pin by the two sync flops and the output flop
        fpu_ignore_error_n_o <= ~(ignore_err & fpu_error_in_n_act); // R17
    end
end

endmodule // ubsd_decoder

// ---- core/ubsd_defs.vh ----
// Constants for the utility bus select decoder
`ifndef UBSD_DEFS_VH
`define UBSD_DEFS_VH
// Encoded select codes, bank low
`define UBSD_CODE_CLK_ADDR 3'h0
`define UBSD_CODE_CLK_DATA 3'h1
`define UBSD_CODE_KBD 3'h2
`define UBSD_CODE_ROM 3'h3
`define UBSD_CODE_DSKT 3'h4
`define UBSD_CODE_DCMD 3'h5
`define UBSD_CODE_DCTL 3'h6
// Encoded select codes, bank high
`define UBSD_CODE_CPAGE 3'h1
`define UBSD_CODE_CRAM 3'h2
`define UBSD_CODE_SERA 3'h3
`define UBSD_CODE_SERB 3'h4
`define UBSD_CODE_PRN 3'h5
`define UBSD_CODE_IDLE 3'h7
// I/O addresses
`define UBSD_IO_CLK_BASE 16'h0070
`define UBSD_IO_KBD_BASE 16'h0060
`define UBSD_IO_DSKT_PRI 16'h03f0
`define UBSD_IO_DSKT_SEC 16'h0370
`define UBSD_IO_DCMD_PRI 16'h01f0
`define UBSD_IO_DCMD_SEC 16'h0170
`define UBSD_IO_DCTL_PRI 16'h03f6
`define UBSD_IO_DCTL_SEC 16'h0376
`define UBSD_IO_DSTAT_PRI 16'h03f7
`define UBSD_IO_DSTAT_SEC 16'h0377
`define UBSD_IO_CPAGE 16'h0c00
`define UBSD_IO_CRAM_BASE 16'h0800
`define UBSD_IO_SER1_BASE 16'h03f8
`define UBSD_IO_SER2_LO 16'h02f8
`define UBSD_IO_SER2_HI 16'h037f
`define UBSD_IO_PRN1_BASE 16'h03bc
`define UBSD_IO_PRN2_BASE 16'h0378
`define UBSD_IO_PRN3_BASE 16'h0278
`define UBSD_IO_SYSCTL 16'h0092
`define UBSD_IO_FPU_CLR 16'h00f0
// Memory windows, upper 16 address bits
`define UBSD_MEM_SEG_F 16'h000f
`define UBSD_MEM_SEG_E 16'h000e
`define UBSD_MEM_TOP_F 16'hffff
`define UBSD_MEM_TOP_E 16'hfffe
`define UBSD_MEM_LOW_F 16'hfff8
`define UBSD_MEM_LOW_E 16'hfff9
`define UBSD_MEM_EXT_LO 16'hfffa
`define UBSD_MEM_EXT_HI 16'hfffd
// Printer range selects
`define UBSD_PRN_SEL1 2'h0
`define UBSD_PRN_SEL2 2'h1
`define UBSD_PRN_SEL3 2'h2
// Port 92h field positions and reset value
`define UBSD_SYSCTL_RST_BIT 0
`define UBSD_SYSCTL_A20_BIT 1
`define UBSD_SYSCTL_RESET 2'h0
// Clock divisor bit that arms the fpu error mode
`define UBSD_FPU_MODE_BIT 5
`endif

// ---- tb/ubsd_far_side.sv ----
// Far side model: both external decoders and the two input pins
`timescale 1ns/100ps
module ubsd_far_side (
    // Select code from the block
    input wire [2:0] code_i,
    input wire bank_n_i,
    // Pin levels requested by the bench
    input wire media_set_i,
    input wire err_set_i,
    // One-hot selects and pins toward the block
    output wire [15:0] sel_n_o,
    output wire media_o,
    output wire err_n_o
);
    // Bank low feeds decoder one, high feeds decoder two
    assign sel_n_o = ~(16'h1 << {bank_n_i, code_i});
    // Cpu error pin is active low
    assign media_o = media_set_i;
    assign err_n_o = ~err_set_i;
endmodule // ubsd_far_side

// ---- tb/ubsd_decoder_chk.sv ----
// Port checker for the select decoder
`timescale 1ns/100ps
module ubsd_chk (
    // Clock, reset, cycle inputs
    input wire ref_clk_i,
    input wire sys_rst_i,
    input wire clk_en_i,
    input wire [31:0] addr_i,
    input wire io_wr_i,
    input wire mem_rd_i,
    input wire mem_wr_i,
    input wire [7:0] clk_divisor_i,
    input wire fpu_error_in_n_i,
    // Watched outputs
    input wire [2:0] encoded_select_code_o,
    input wire decoder_bank_select_n_o,
    input wire irq13_o,
    input wire fpu_ignore_error_n_o
);
    // Short names; a memory cycle wins over an I/O one
    wire [2:0] code = encoded_select_code_o;
    wire bank = decoder_bank_select_n_o;
    wire iow = clk_en_i && io_wr_i && !mem_rd_i && !mem_wr_i;
    wire run = clk_en_i && clk_divisor_i[5];
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    a_rst_idle: assert property (disable iff (1'h0)
        sys_rst_i && clk_en_i |=> code == 3'h7 && bank) else $error("no idle");
    a_clk_addr_wr: assert property (iow && addr_i == 32'h70
        |=> code == 3'h0 && !bank) else $error("clock addr select");
    a_rom_top: assert property (clk_en_i && mem_rd_i
        && addr_i[31:16] == 16'hf |=> code == 3'h3 && !bank)
        else $error("boot select");
    a_cfg_page: assert property (iow && addr_i == 32'hc00
        |=> code == 3'h1 && bank) else $error("page select");
    a_no_reserved: assert property (!(!bank && code == 3'h7)
        && !(bank && (code == 3'h0 || code == 3'h6))) else $error("reserved");
    a_irq_mode: assert property ((clk_en_i && !clk_divisor_i[5])[*4]
        |-> !irq13_o) else $error("irq with mode off");
    a_ign_error: assert property ((clk_en_i && fpu_error_in_n_i)[*5]
        |-> fpu_ignore_error_n_o) else $error("ignore without error");
    a_f0_clear: assert property ((run && !fpu_error_in_n_i)[*4]
        ##0 (iow && irq13_o && addr_i == 32'hf0)
        |-> ##2 (!irq13_o && !fpu_ignore_error_n_o)) else $error("f0 clear");
endmodule // ubsd_chk

bind ubsd_decoder ubsd_chk u_chk (.ref_clk_i, .sys_rst_i, .clk_en_i, .addr_i,
    .io_wr_i, .mem_rd_i, .mem_wr_i, .clk_divisor_i, .fpu_error_in_n_i,
    .encoded_select_code_o, .decoder_bank_select_n_o, .irq13_o,
    .fpu_ignore_error_n_o);

// ---- tb/tb.sv ----
// Self-checking bench for the select decoder
`timescale 1ns/100ps
module tb;
    // Design inputs, all valued at time zero
    reg ref_clk_i = 1'h0, sys_rst_i = 1'h1, clk_en_i = 1'h1;
    reg io_rd_i = 1'h0, io_wr_i = 1'h0, mem_rd_i = 1'h0, mem_wr_i = 1'h0;
    reg [31:0] addr_i = 32'h0;
    reg [7:0] wr_data_i = 8'h0, clk_divisor_i = 8'h0;
    reg rom_low_seg_en_i = 1'h1, rom_ext_en_i = 1'h0, dskt_dec_en_i = 1'h1;
    reg disk_dec_en_i = 1'h1, disk_secondary_i = 1'h0, printer_en_i = 1'h1;
    reg serial_a_second_i = 1'h0, serial_b_second_i = 1'h1;
    reg serial_a_en_i = 1'h1, serial_b_en_i = 1'h1, media = 1'h1, err = 1'h0;
    reg [1:0] printer_range_i = 2'h0;
    // Design outputs and far side pins
    wire [2:0] encoded_select_code_o;
    wire decoder_bank_select_n_o, sd7_o, sd7_oe_o, util_buffer_out_en_n_o;
    wire util_buffer_direction_o, alternate_reset_o, alternate_gate_a20_o;
    wire irq13_o, int_o, fpu_ignore_error_n_o, media_change_in_i;
    wire fpu_error_in_n_i;
    wire [15:0] sel_n;
    integer fails = 0, n_checks = 0, i;
    reg [39:0] r;
    // Kind (io rd, io wr, mem rd, mem wr), address, {bank, code}
    logic [39:0] rows [17] = '{40'h4000000700, 40'h800000070f,
        40'h8000000731, 40'h4000000662, 40'h2000f12343, 40'h1ffff00003,
        40'h2000e00003, 40'h8000003f04, 40'h4000001f75, 40'h8000003f66,
        40'h800000170f, 40'h400000c009, 40'h8000008ffa, 40'h8000003f8b,
        40'h4000002f8c, 40'h8000003bcd, 40'h800000278f};
    logic [31:0] pa [3] = '{32'h3bc, 32'h378, 32'h278};
    ubsd_decoder dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i), .addr_i(addr_i), .io_rd_i(io_rd_i),
        .io_wr_i(io_wr_i), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i),
        .wr_data_i(wr_data_i), .rom_low_seg_en_i(rom_low_seg_en_i),
        .rom_ext_en_i(rom_ext_en_i), .dskt_dec_en_i(dskt_dec_en_i),
        .disk_dec_en_i(disk_dec_en_i), .disk_secondary_i(disk_secondary_i),
        .serial_a_second_i(serial_a_second_i),
        .serial_b_second_i(serial_b_second_i),
        .serial_a_en_i(serial_a_en_i), .serial_b_en_i(serial_b_en_i),
        .printer_range_i(printer_range_i), .printer_en_i(printer_en_i),
        .clk_divisor_i(clk_divisor_i), .media_change_in_i(media_change_in_i),
        .fpu_error_in_n_i(fpu_error_in_n_i),
        .encoded_select_code_o(encoded_select_code_o),
        .decoder_bank_select_n_o(decoder_bank_select_n_o),
        .sd7_o(sd7_o), .sd7_oe_o(sd7_oe_o),
        .util_buffer_out_en_n_o(util_buffer_out_en_n_o),
        .util_buffer_direction_o(util_buffer_direction_o),
        .alternate_reset_o(alternate_reset_o),
        .alternate_gate_a20_o(alternate_gate_a20_o), .irq13_o(irq13_o),
        .int_o(int_o), .fpu_ignore_error_n_o(fpu_ignore_error_n_o));
    ubsd_far_side u_far (.code_i(encoded_select_code_o),
        .bank_n_i(decoder_bank_select_n_o), .media_set_i(media),
        .err_set_i(err), .sel_n_o(sel_n), .media_o(media_change_in_i),
        .err_n_o(fpu_error_in_n_i));
    // Compare and count; four-state equality so unknowns fail
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One access; selects and buffer enable show one edge later
    task acc(input [3:0] kk, input [31:0] a, input [3:0] e, input on);
        @(negedge ref_clk_i);
        {io_rd_i, io_wr_i, mem_rd_i, mem_wr_i} = kk;
        addr_i = a;
        @(negedge ref_clk_i);
        {io_rd_i, io_wr_i, mem_rd_i, mem_wr_i} = 4'h0;
        chk("sel_n", sel_n, 16'(~(16'h1 << e)));
        chk("oe_n", util_buffer_out_en_n_o, on);
        chk("dir", util_buffer_direction_o, kk[3] | kk[1]);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Clock, 25 ns period
    initial begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    // Watchdog, over twenty times the expected run
    initial begin
        #(25 * 3000);
        fails++;
        wrap_up;
    end
    // Main sequence
    initial begin
        repeat (20) @(negedge ref_clk_i);
        sys_rst_i = 1'h0;
        chk("rst_sel", sel_n, 16'h7fff);
        chk("rst_alt", alternate_reset_o, 1'h0);
        chk("rst_ign", fpu_ignore_error_n_o, 1'h1);
        for (i = 0; i < 17; i++) begin
            r = rows[i];
            acc(r[39:36], r[35:4], r[3:0], r[3:0] == 4'hf);
        end
        $display("reset and table done");
        // Boot windows under enable control
        rom_ext_en_i = 1'h1;
        rom_low_seg_en_i = 1'h0;
        acc(4'h2, 32'hfffd0000, 4'h3, 1'h0);
        acc(4'h1, 32'hfffe0000, 4'hf, 1'h1);
        acc(4'h2, 32'hffff0000, 4'h3, 1'h0);
        // Printer ranges; serial B off to keep 378h free
        serial_b_en_i = 1'h0;
        for (i = 0; i < 3; i++) begin
            printer_range_i = i[1:0];
            acc(4'h8, pa[i], 4'hd, 1'h0);
            acc(4'h4, pa[(i + 1) % 3], 4'hf, 1'h1);
        end
        // Range code 3 and printer off both leave the port unmapped
        printer_range_i = 2'h3;
        acc(4'h8, 32'h278, 4'hf, 1'h1);
        printer_range_i = 2'h2;
        printer_en_i = 1'h0;
        acc(4'h8, 32'h278, 4'hf, 1'h1);
        printer_en_i = 1'h1;
        disk_secondary_i = 1'h1;
        acc(4'h8, 32'h170, 4'h5, 1'h0);
        acc(4'h4, 32'h1f0, 4'hf, 1'h1);
        serial_a_second_i = 1'h1;
        serial_b_en_i = 1'h1;
        serial_b_second_i = 1'h0;
        acc(4'h8, 32'h2f8, 4'hb, 1'h0);
        acc(4'h4, 32'h3ff, 4'hc, 1'h0);
        $display("window tests done");
        // Media change on bit 7; serial A off, it overlaps 377h
        serial_a_en_i = 1'h0;
        disk_dec_en_i = 1'h0;
        acc(4'h8, 32'h377, 4'h4, 1'h1);
        chk("sd7", {sd7_oe_o, sd7_o}, 2'h2);
        disk_dec_en_i = 1'h1;
        acc(4'h8, 32'h377, 4'h6, 1'h0);
        chk("sd7_oe", sd7_oe_o, 1'h0);
        media = 1'h0;
        disk_secondary_i = 1'h0;
        disk_dec_en_i = 1'h0;
        repeat (3) @(negedge ref_clk_i);
        acc(4'h8, 32'h3f7, 4'h4, 1'h1);
        chk("sd7", {sd7_oe_o, sd7_o}, 2'h3);
        // Port 92h bits, two edges after the write
        wr_data_i = 8'h02;
        acc(4'h4, 32'h92, 4'hf, 1'h1);
        repeat (2) @(negedge ref_clk_i);
        chk("alt", {alternate_reset_o, alternate_gate_a20_o}, 2'h1);
        // Enable low freezes decode and port 92h
        clk_en_i = 1'h0;
        wr_data_i = 8'h01;
        acc(4'h4, 32'h70, 4'hf, 1'h1);
        acc(4'h4, 32'h92, 4'hf, 1'h1);
        repeat (2) @(negedge ref_clk_i);
        chk("hold", {alternate_reset_o, alternate_gate_a20_o}, 2'h1);
        clk_en_i = 1'h1;
        // Error held with mode off, then mode on, clear, release
        err = 1'h1;
        repeat (8) @(negedge ref_clk_i);
        chk("irq", irq13_o, 1'h0);
        clk_divisor_i = 8'h20;
        repeat (4) @(negedge ref_clk_i);
        chk("irq", {irq13_o, int_o, fpu_ignore_error_n_o}, 3'h7);
        acc(4'h4, 32'hf0, 4'hf, 1'h1);
        repeat (2) @(negedge ref_clk_i);
        chk("ign", {irq13_o, fpu_ignore_error_n_o}, 2'h0);
        err = 1'h0;
        repeat (6) @(negedge ref_clk_i);
        chk("ign_n", fpu_ignore_error_n_o, 1'h1);
        $display("pin tests done");
        // Reset in mid-run with a request standing
        err = 1'h1;
        repeat (6) @(negedge ref_clk_i);
        chk("irq_up", irq13_o, 1'h1);
        sys_rst_i = 1'h1;
        repeat (2) @(negedge ref_clk_i);
        sys_rst_i = 1'h0;
        chk("rst2", {alternate_gate_a20_o, irq13_o, int_o}, 3'h0);
        chk("rst2_ign", fpu_ignore_error_n_o, 1'h1);
        $display("mid-run reset done");
        wrap_up;
    end
endmodule // tb
